// ===== core/ssrp_pkg.sv
/*
  Shared constants and types for the serial register port.
  Assumes one 20 MHz reference clock samples every pin of the link.
*/
package ssrp_pkg;

  // bus identity and byte layout
  localparam logic [6:0] DEV_ADDR = 7'h5f;
  localparam logic [4:0] MCODE_TOP = 5'h01;
  localparam int MCODE_LSB = 3;
  localparam int SUB_INC_POS = 7;
  localparam int SPI_RW_POS = 7;
  localparam int SPI_INC_POS = 6;

  // bit counts
  localparam logic [3:0] I2C_BITS = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h7;
  localparam logic [3:0] SPI_CMD_LAST = 4'h7;
  localparam logic [3:0] SPI_LAST = 4'hf;
  localparam logic [3:0] SPI_LOOP = 4'h8;

  // reset values
  localparam logic [6:0] PTR_RST = 7'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RX = 7'h02,
    ST_ACK = 7'h04,
    ST_FETCH = 7'h08,
    ST_TX = 7'h10,
    ST_MACK = 7'h20,
    ST_SPI = 7'h40
  } ssrp_state_t;

  typedef enum logic [2:0] {
    K_ADDR = 3'h1,
    K_SUB = 3'h2,
    K_DATA = 3'h4
  } ssrp_kind_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic cs_n;
  } ssrp_pins_t;

  localparam ssrp_pins_t PINS_RST = '{scl: 1'b1, sda: 1'b1, cs_n: 1'b1};

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } ssrp_req_t;

endpackage : ssrp_pkg

// ===== core/ssrp_port.sv
/*
  Serial register port: I2C slave (with high-speed entry and exit) and a
  3-wire SPI slave sharing clock and data pins, chosen by the select pin.
  Assumes the register file sits on ref_clk and returns reg_rdata in the
  same cycle that reg_req.rd is high; pins are asynchronous to ref_clk.
*/
`timescale 1ns/1ps

// Function
// - START is data falling while clock high; bus then busy.
// - first byte holds seven address bits plus direction; answer only on match.
// - own address is 1011111; direction 1 reads, 0 writes.
// - sender releases data at acknowledge; receiver holds it low through clock high.
// - sub-address low seven bits pick register; top bit enables pointer advance.
// - read: write address, sub-address, repeated start, read address, then data.
// - write: data bytes each acknowledged and stored until STOP.
// - read continues while host acknowledges; host not-acknowledge then STOP ends.
// - bytes are eight bits, most significant first, any count per transfer.
// - a receiver not ready may hold clock low to stall.
// - unaccepted address leaves data high as not-acknowledge.
// - STOP is data rising while clock high; ends every transfer.
// - high speed only after START, master code 00001xxx, not-acknowledge.
// - high speed persists over repeated starts; STOP returns normal speed.
// - SPI works in clock modes 0 and 3 on three lines.
// - SPI data changes on falling clock, sampled on rising clock.
// - single access is 16 pulses; each extra byte adds 8.
// - bit 0 starts at first falling edge after select falls.
// - first SPI bit: 0 write, 1 read.
// - second SPI bit: 1 advances pointer after each data byte.
// - SPI bits 2-7 register index, then data bytes msb first.
// - select high picks I2C; select low picks SPI; pins shared.
module ssrp_port
  import ssrp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // shared serial pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic cs_n_in,
  // register side
  output ssrp_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  // status
  output logic bus_busy,
  output logic hs_mode
);

  ssrp_pins_t sy1_r, sy2_r, pv_r;
  ssrp_state_t st_r, st_nxt;
  ssrp_kind_t kind_r, kind_nxt;
  ssrp_req_t req_r, req_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, buf_r, buf_nxt;
  logic [6:0] ptr_r, ptr_nxt;
  logic rw_r, rw_nxt, inc_r, inc_nxt, nack_r, nack_nxt, drv_r, drv_nxt;
  logic hs_r, hs_nxt, hsp_r, hsp_nxt, busy_r, busy_nxt;
  logic sda_out_r, sda_oe_r, scl_oe_r, scl_out_r;
  logic sda_out_nxt, sda_oe_nxt, scl_oe_nxt;

  // edge and condition decode on the synchronised pins
  wire logic scl_rise = sy2_r.scl & ~pv_r.scl;
  wire logic scl_fall = ~sy2_r.scl & pv_r.scl;
  wire logic i2c_en = sy2_r.cs_n & pv_r.cs_n;
  wire logic start = i2c_en & sy2_r.scl & pv_r.scl & pv_r.sda & ~sy2_r.sda;
  wire logic stop = i2c_en & sy2_r.scl & pv_r.scl & ~pv_r.sda & sy2_r.sda;
  wire logic spi_go = ~sy2_r.cs_n & pv_r.cs_n;
  wire logic spi_end = sy2_r.cs_n & ~pv_r.cs_n;
  wire logic [7:0] rxb = {sh_r[6:0], sy2_r.sda};
  wire logic addr_hit = (sh_r[7:1] == DEV_ADDR);
  wire logic mcode = (sh_r[7:MCODE_LSB] == MCODE_TOP);
  wire logic [3:0] cnt_inc = cnt_r + 4'h1;
  wire logic spi_tx = rw_r & cnt_r[3];
  wire logic [6:0] spi_idx = {1'b0, rxb[5:0]};

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sy1_r <= PINS_RST;
      sy2_r <= PINS_RST;
      pv_r <= PINS_RST;
    end else begin
      sy1_r <= '{scl: scl_in, sda: sda_in, cs_n: cs_n_in};
      sy2_r <= sy1_r;
      pv_r <= sy2_r;
    end
  end

  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    buf_nxt = buf_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    inc_nxt = inc_r;
    nack_nxt = nack_r;
    drv_nxt = drv_r;
    hs_nxt = hs_r;
    hsp_nxt = hsp_r;
    busy_nxt = busy_r;
    req_nxt = '0;
    req_nxt.addr = ptr_r;
    scl_oe_nxt = 1'b0;
    if ((req_r.rd | req_r.wr) & inc_r) begin
      ptr_nxt = ptr_r + 7'h1;
    end
    case (st_r)
      ST_IDLE: begin
      end
      ST_RX: begin
        if (scl_rise) begin
          sh_nxt = rxb;
          cnt_nxt = cnt_inc;
        end else if (scl_fall && cnt_r == I2C_BITS) begin
          cnt_nxt = '0;
          st_nxt = ST_ACK;
          if (kind_r == K_ADDR) begin
            rw_nxt = sh_r[0];
            kind_nxt = K_SUB;
            if (!addr_hit) begin
              st_nxt = ST_IDLE;
              hsp_nxt = mcode;
            end
          end else if (kind_r == K_SUB) begin
            ptr_nxt = sh_r[6:0];
            inc_nxt = sh_r[SUB_INC_POS];
            kind_nxt = K_DATA;
          end else begin
            req_nxt.wr = 1'b1;
            req_nxt.wdata = sh_r;
          end
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          st_nxt = ST_RX;
          if (kind_r == K_SUB && rw_r) begin
            st_nxt = ST_FETCH;
            req_nxt.rd = 1'b1;
            scl_oe_nxt = 1'b1;
          end
        end
      end
      ST_FETCH: begin
        scl_oe_nxt = ~req_r.rd;
        if (req_r.rd) begin
          sh_nxt = reg_rdata;
          cnt_nxt = '0;
          st_nxt = ST_TX;
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          sh_nxt = {sh_r[6:0], 1'b0};
          cnt_nxt = cnt_inc;
          if (cnt_r == TX_LAST) begin
            st_nxt = ST_MACK;
          end
        end
      end
      ST_MACK: begin
        if (scl_rise) begin
          nack_nxt = sy2_r.sda;
        end else if (scl_fall) begin
          st_nxt = nack_r ? ST_IDLE : ST_FETCH;
          req_nxt.rd = ~nack_r;
          scl_oe_nxt = ~nack_r;
        end
      end
      ST_SPI: begin
        if (scl_rise) begin
          cnt_nxt = (cnt_r == SPI_LAST) ? SPI_LOOP : cnt_inc;
          if (!spi_tx) begin
            sh_nxt = rxb;
          end
          if (cnt_r == SPI_CMD_LAST) begin
            rw_nxt = rxb[SPI_RW_POS];
            inc_nxt = rxb[SPI_INC_POS];
            ptr_nxt = spi_idx;
            req_nxt.addr = spi_idx;
            req_nxt.rd = rxb[SPI_RW_POS];
          end
          if (cnt_r == SPI_LAST) begin
            req_nxt.rd = rw_r;
            req_nxt.wr = ~rw_r;
            req_nxt.wdata = rxb;
          end
        end else if (scl_fall && spi_tx) begin
          drv_nxt = 1'b1;
          sh_nxt = (cnt_r[2:0] == 3'h0) ? buf_r : {sh_r[6:0], 1'b0};
        end
        if (req_r.rd) begin
          buf_nxt = reg_rdata;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (start) begin
      st_nxt = ST_RX;
      kind_nxt = K_ADDR;
      cnt_nxt = '0;
      busy_nxt = 1'b1;
      hs_nxt = hs_r | hsp_r;
      hsp_nxt = 1'b0;
    end
    if (stop) begin
      st_nxt = ST_IDLE;
      busy_nxt = 1'b0;
      hs_nxt = 1'b0;
      hsp_nxt = 1'b0;
    end
    if (spi_go) begin
      st_nxt = ST_SPI;
      cnt_nxt = '0;
      rw_nxt = 1'b0;
      drv_nxt = 1'b0;
      busy_nxt = 1'b0;
    end
    if (spi_end) begin
      st_nxt = ST_IDLE;
      drv_nxt = 1'b0;
    end
  end

  // open-drain in I2C, push-pull only while SPI read data is out
  assign sda_oe_nxt = (st_nxt == ST_ACK) | ((st_nxt == ST_TX) & ~sh_nxt[7])
                    | ((st_nxt == ST_SPI) & drv_nxt);
  assign sda_out_nxt = (st_nxt == ST_SPI) & sh_nxt[7];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_IDLE;
      kind_r <= K_ADDR;
      cnt_r <= '0;
      sh_r <= BYTE_RST;
      buf_r <= BYTE_RST;
      ptr_r <= PTR_RST;
      rw_r <= 1'b0;
      inc_r <= 1'b0;
      nack_r <= 1'b1;
      drv_r <= 1'b0;
      hs_r <= 1'b0;
      hsp_r <= 1'b0;
      busy_r <= 1'b0;
      req_r <= '0;
      sda_out_r <= 1'b0;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
      scl_out_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      buf_r <= buf_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      inc_r <= inc_nxt;
      nack_r <= nack_nxt;
      drv_r <= drv_nxt;
      hs_r <= hs_nxt;
      hsp_r <= hsp_nxt;
      busy_r <= busy_nxt;
      req_r <= req_nxt;
      sda_out_r <= sda_out_nxt;
      sda_oe_r <= sda_oe_nxt;
      scl_oe_r <= scl_oe_nxt;
      scl_out_r <= 1'b0;
    end
  end

  assign scl_out = scl_out_r;
  assign scl_oe = scl_oe_r;
  assign sda_out = sda_out_r;
  assign sda_oe = sda_oe_r;
  assign reg_req = req_r;
  assign bus_busy = busy_r;
  assign hs_mode = hs_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  start_busy_a: assert property (start |=> busy_r && st_r == ST_RX)
    else $error("start did not mark bus busy");
  stop_idle_a: assert property (stop |=> st_r == ST_IDLE && !busy_r)
    else $error("stop did not end transfer");
  ack_hold_a: assert property ((st_r == ST_ACK) ##1 (st_r == ST_ACK) |-> sda_oe_r)
    else $error("acknowledge not held low");
  miss_quiet_a: assert property (st_r == ST_RX && scl_fall && !addr_hit
      && cnt_r == I2C_BITS && kind_r == K_ADDR |=> !sda_oe_r ##1 !sda_oe_r)
    else $error("data driven while not addressed");
  mcode_nack_a: assert property (st_r == ST_RX && scl_fall && cnt_r == I2C_BITS
      && kind_r == K_ADDR && mcode |=> st_r == ST_IDLE && hsp_r)
    else $error("master code was acknowledged");
  hs_exit_a: assert property (stop |=> !hs_r ##1 !hs_r)
    else $error("high speed kept after stop");
  ptr_step_a: assert property ((req_r.wr || req_r.rd) && inc_r
      |=> ptr_r == $past(req_r.addr) + 7'h1)
    else $error("pointer did not advance");
  spi_wr_a: assert property (st_r == ST_SPI && req_r.wr |-> cnt_r == SPI_LOOP
      && !rw_r)
    else $error("spi write at wrong bit count");
  spi_rel_a: assert property (sy2_r.cs_n ##1 sy2_r.cs_n |-> !drv_r)
    else $error("spi data driven with select high");
  fetch_load_a: assert property (st_r == ST_FETCH && req_r.rd
      |=> st_r == ST_TX && sh_r == $past(reg_rdata) && !scl_oe_r)
    else $error("read byte not loaded");

  i2c_write_c: cover property (st_r == ST_RX && kind_r == K_DATA ##1 req_r.wr);
  i2c_read_c: cover property (st_r == ST_MACK ##[1:200] st_r == ST_FETCH);
  spi_read_c: cover property (st_r == ST_SPI && drv_r && cnt_r == SPI_LAST);
  hs_enter_c: cover property (!hs_r ##1 hs_r);

endmodule : ssrp_port

// ===== tb/ssrp_host.sv
/*
  Host master model for the serial register port: I2C and 3-wire SPI on shared pins.
  Assumes the port drives open-drain enables and is sampled by its own 20 MHz clock.
*/
`timescale 1ns/1ps
module ssrp_host (
  // pins toward the port
  output logic scl,
  output logic sda,
  output logic cs_n,
  // port drives
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe
);
  logic scl_d = 1'b1;
  logic sda_d = 1'b1;
  logic spi_d = 1'b0;
  logic last = 1'b1;
  int tmo = 0;
  initial cs_n = 1'b1;
  // pull-ups in i2c; spi line with no driver shows the inverse of its last value
  assign scl = scl_d & ~(scl_oe & ~scl_out);
  assign sda = cs_n ? (sda_d & ~(sda_oe & ~sda_out)) : sda_oe ? sda_out : spi_d ? sda_d : ~last;
  always @(negedge sda_oe) last = sda_out;
  always @(negedge spi_d) last = sda_d;
  // release clock, wait while the port stretches it
  task automatic hi();
    int n;
    n = 0;
    scl_d = 1'b1;
    while (scl !== 1'b1 && n < 200) begin
      #50;
      n++;
    end
    if (scl !== 1'b1) tmo++;
    #200;
  endtask : hi
  // data changes mid low phase, sampled at end of high
  task automatic bit_x(input logic b, output logic s);
    #100 sda_d = b;
    #100;
    hi();
    s = sda;
    scl_d = 1'b0;
  endtask : bit_x
  task automatic start();
    #100 sda_d = 1'b1;
    #100;
    hi();
    sda_d = 1'b0;
    #200 scl_d = 1'b0;
    #200;
  endtask : start
  task automatic stop();
    #100 sda_d = 1'b0;
    #100;
    hi();
    sda_d = 1'b1;
    #400;
  endtask : stop
  task automatic byte_w(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask : byte_w
  task automatic byte_r(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~mack, s);
  endtask : byte_r
  // mode 3: clock parked high while select is high
  task automatic spi_bit(input logic b, output logic s);
    scl_d = 1'b0;
    #100 sda_d = b;
    #100 scl_d = 1'b1;
    #200 s = sda;
  endtask : spi_bit
  task automatic spi_xfer(input logic [7:0] cmd, input logic [15:0] wd,
                          output logic [15:0] rd);
    logic s;
    cs_n = 1'b0;
    spi_d = 1'b1;
    #400;
    for (int i = 7; i >= 0; i--) spi_bit(cmd[i], s);
    spi_d = ~cmd[7];
    for (int i = 15; i >= 0; i--) spi_bit(wd[i], rd[i]);
    #200 cs_n = 1'b1;
    spi_d = 1'b0;
    sda_d = 1'b1;
    #400;
  endtask : spi_xfer
endmodule : ssrp_host

// ===== tb/ssrp_port_test.sv
/*
  Self-checking bench for the serial register port, with a small register file model.
  Assumes ssrp_host as the far-side master and ssrp_pkg for the request struct.
*/
`timescale 1ns/1ps
module ssrp_port_test;
  import ssrp_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic scl, sda, cs_n, scl_out, scl_oe, sda_out, sda_oe, bus_busy, hs_mode;
  ssrp_req_t reg_req;
  wire logic [7:0] reg_rdata;
  logic [7:0] mem [128];
  logic [15:0] wlog [$];
  int n_errors = 0;
  int cmp_count = 0;
  int n_hold = 0;
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (scl_oe === 1'b1) n_hold++;
  assign reg_rdata = mem[reg_req.addr];
  always @(posedge ref_clk) if (reg_req.wr === 1'b1) wlog.push_back({1'b0, reg_req.addr, reg_req.wdata});
  ssrp_port u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .cs_n_in(cs_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .bus_busy(bus_busy), .hs_mode(hs_mode));
  ssrp_host u_host (.scl(scl), .sda(sda), .cs_n(cs_n), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe));
  function automatic logic [7:0] pat(input logic [6:0] a);
    return {a, 1'b0} ^ 8'h3c;
  endfunction : pat
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic ok(input string name);
    $display("test %s done", name);
    if (u_host.tmo != 0) begin
      n_errors++;
      wrap_up();
    end
  endtask : ok
  task automatic t_i2c_wr();
    logic a0, a1, a2, a3;
    wlog.delete();
    u_host.start();
    chk(bus_busy, 16'h1);
    u_host.byte_w(8'hbe, a0);
    u_host.byte_w(8'h85, a1);
    u_host.byte_w(8'ha5, a2);
    u_host.byte_w(8'h3c, a3);
    u_host.stop();
    chk({a0, a1, a2, a3}, 16'hf);
    chk(wlog.size(), 16'h2);
    chk(wlog[0], {1'b0, 7'h05, 8'ha5});
    chk(wlog[1], {1'b0, 7'h06, 8'h3c});
    chk(bus_busy, 16'h0);
    ok("i2c write");
  endtask : t_i2c_wr
  task automatic t_i2c_rd();
    logic a0, a1, a2;
    logic [7:0] d0, d1;
    n_hold = 0;
    u_host.start();
    u_host.byte_w(8'hbe, a0);
    u_host.byte_w(8'h90, a1);
    u_host.start();
    u_host.byte_w(8'hbf, a2);
    u_host.byte_r(1'b1, d0);
    u_host.byte_r(1'b0, d1);
    u_host.stop();
    chk({a0, a1, a2}, 16'h7);
    chk(d0, pat(7'h10));
    chk(d1, pat(7'h11));
    chk(n_hold, 16'h2);
    chk(scl_out, 16'h0);
    ok("i2c read");
  endtask : t_i2c_rd
  // wrong address, then our own address in the same transfer must stay unanswered
  task automatic t_nak();
    logic a0, a1;
    wlog.delete();
    u_host.start();
    u_host.byte_w(8'ha0, a0);
    u_host.byte_w(8'hbe, a1);
    u_host.stop();
    chk(a0, 16'h0);
    chk(a1, 16'h0);
    chk(wlog.size(), 16'h0);
    ok("nak");
  endtask : t_nak
  task automatic t_hs();
    logic a0, a1, a2;
    for (int k = 0; k < 8; k++) begin
      u_host.start();
      u_host.byte_w({5'h01, k[2:0]}, a0);
      chk(a0, 16'h0);
      u_host.start();
      chk(hs_mode, 16'h1);
      u_host.byte_w(8'hbe, a1);
      u_host.byte_w(8'h01, a2);
      u_host.start();
      chk(hs_mode, 16'h1);
      chk({a1, a2}, 16'h3);
      u_host.stop();
      chk(hs_mode, 16'h0);
    end
    ok("high speed");
  endtask : t_hs
  task automatic t_spi_wr();
    logic [15:0] rd;
    for (int inc = 0; inc < 2; inc++) begin
      wlog.delete();
      u_host.spi_xfer({1'b0, inc[0], 6'h08}, 16'h5ac3, rd);
      chk(wlog.size(), 16'h2);
      chk(wlog[0], {1'b0, 7'h08, 8'h5a});
      chk(wlog[1], {1'b0, 7'h08 + inc[6:0], 8'hc3});
      chk(bus_busy, 16'h0);
    end
    ok("spi write");
  endtask : t_spi_wr
  task automatic t_spi_rd();
    logic [15:0] rd;
    for (int inc = 0; inc < 2; inc++) begin
      u_host.spi_xfer({1'b1, inc[0], 6'h0a}, 16'h0000, rd);
      chk(rd, {pat(7'h0a), pat(7'h0a + inc[6:0])});
      chk(sda_oe, 16'h0);
    end
    ok("spi read");
  endtask : t_spi_rd
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = pat(i[6:0]);
    repeat (5) @(posedge ref_clk);
    #2 arst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #2;
    t_i2c_wr();
    t_i2c_rd();
    t_nak();
    t_hs();
    t_spi_wr();
    t_spi_rd();
    wrap_up();
  end
  // hang guard
  initial begin
    #2ms;
    n_errors++;
    wrap_up();
  end
endmodule : ssrp_port_test
